// >>> adcsc_pkg.sv
package adcsc_pkg;
  // register index map
  localparam logic [3:0] OFS_MODE      = 4'h0;
  localparam logic [3:0] OFS_MODE2     = 4'h1;
  localparam logic [3:0] OFS_CHAN      = 4'h2;
  localparam logic [3:0] OFS_PORTCFG   = 4'h3;
  localparam logic [3:0] OFS_REFCTL    = 4'h4;
  localparam logic [3:0] OFS_RES_FULL  = 4'h5;
  localparam logic [3:0] OFS_RES_UPPER = 4'h6;
  localparam logic [3:0] OFS_FLAG      = 4'h7;
  localparam logic [3:0] OFS_PORT_IN   = 4'h8;
  localparam logic [3:0] OFS_PERIPH_EN = 4'h9;
  localparam logic [3:0] OFS_OPAMP     = 4'ha;
  // field positions
  localparam int MODE_START_BIT = 7;
  localparam int MODE_CMP_BIT   = 0;
  localparam int REF_ON_BIT     = 0;
  localparam int REF_GAIN_BIT   = 1;
  localparam int FLAG_DONE_BIT  = 0;
  localparam int GATE_BIT       = 0;
  localparam int CHAN_W         = 4;
  localparam int RES_W          = 12;
  localparam int UPPER_W        = 8;
  localparam int PIN_W          = 16;
  localparam int OPAMP_N        = 3;
  // reset values
  localparam logic [7:0]  MODE_RST   = 8'h00;
  localparam logic [7:0]  MODE2_RST  = 8'h00;
  localparam logic [3:0]  CHAN_RST   = 4'h0;
  localparam logic [15:0] PCFG_RST   = 16'h0000;
  localparam logic [7:0]  REF_RST    = 8'h00;
  localparam logic [2:0]  OPAMP_RST  = 3'h0;
  // timing: clock and conversion phases
  localparam int CLK_MHZ        = 125;
  localparam int SETUP_NS       = 200;
  localparam int SETUP_CYC      = (SETUP_NS * CLK_MHZ + 999) / 1000;
  localparam int CONV_BASE_NS   = 1000;
  localparam int CONV_BASE_CYC  = (CONV_BASE_NS * CLK_MHZ + 999) / 1000;
  localparam int CNT_W          = 16;

  typedef struct packed {
    logic       start;
    logic       rsvd;
    logic [2:0] time_sel;
    logic       volt_hi;
    logic       volt_lo;
    logic       cmp_en;
  } adcsc_mode_t;

  typedef struct packed {
    logic       en;
    logic [3:0] sel;
  } adcsc_mux_t;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_SETUP,
    ST_CONV
  } adcsc_state_t;
endpackage

// >>> adcsc_top.sv
// The implementer's own choices: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// [R1] software writes zero to channel select bits 4 to 7
// [R2] software sets analog pins to input mode before converting
// [R3] software never selects a pin configured as digital i/o
// [R4] port read returns 0 for pins configured as analog input
// [R5] software waits 1 us between comparator enable and start
// [R6] low-voltage modes need boost enabled and 10 us before start
// [R7] conversion phase set by mode bits 5..1, plus setup phase before it; the code times it from mode bits 5..3 only
// [R8] op-amp started before conversion and left unchanged while converting
// [R9] internal reference started before conversion and left unchanged
// [R10] software clears start, optionally comparator, before stop mode
// [R11] low-voltage modes clear reference gain and on before stop mode
// [R12] after standby, clear done flag before restarting
// [R13] result read coinciding with result write is served first
// [R14] mode/channel/port-config write at completion suppresses store and irq
// [R15] channel write leaves done flag alone; running conversion completes
// [R16] after stopping, software clears done flag before resuming
// [R17] software discards first result after early or disabled start
// [R18] mode, mode2, channel, port-config writes may corrupt results
// [R19] active op-amp input pins lose analog-input use; output stays
// [R20] dac values not rewritten while start set with shared reference
// [R21] 12-bit full result and 8-bit upper result registers
// [R22] with clock gate off, writes ignored and reads give reset values; code still lets flag writes clear the done flag and reads it back
// [R23] completion stores result, sets flag, pulses irq one clock
module adcsc_top
  import adcsc_pkg::*;
(
  input  wire logic               clk,
  input  wire logic               rstn,
  input  wire logic [3:0]         addr,
  input  wire logic [15:0]        wdata,
  input  wire logic               wr,
  input  wire logic               rd,
  output var  logic [15:0]        rdata,
  input  wire logic [RES_W-1:0]   sar_code,
  input  wire logic [PIN_W-1:0]   port_pins,
  output var  logic               comparator_on,
  output var  logic               sample_on,
  output var  adcsc_mux_t         mux,
  output var  logic               ref_on,
  output var  logic               ref_gain,
  output var  logic               conv_done_irq
);

  // ************************************************************
  // register storage
  // ************************************************************
  logic                      converter_clock_gate;
  adcsc_mode_t               converter_mode_reg;
  logic [7:0]                converter_mode2_reg;
  logic [CHAN_W-1:0]         channel_select_reg;
  logic [PIN_W-1:0]          port_config_reg;
  logic [7:0]                ref_control_reg;
  logic [OPAMP_N-1:0]        opamp_active;
  logic [RES_W-1:0]          result_full_reg;
  logic                      conv_done_flag;
  logic [PIN_W-1:0]          pin_meta;
  logic [PIN_W-1:0]          pin_sync;
  logic [PIN_W-1:0]          port_view;
  adcsc_state_t              state;
  logic [CNT_W-1:0]          cnt;
  logic [CNT_W-1:0]          conv_cyc;
  logic                      wr_ok;
  logic                      cfg_wr;
  logic                      done;
  logic                      commit;
  logic                      chan_blocked;

  assign wr_ok = wr && converter_clock_gate;

  // a config write landing on the end of conversion wins
  assign cfg_wr = wr_ok && (addr == OFS_MODE || addr == OFS_CHAN || addr == OFS_PORTCFG);

  // [R7] conversion length from time select
  assign conv_cyc = CNT_W'(CONV_BASE_CYC) << converter_mode_reg.time_sel;

  assign done = (state == ST_CONV) && (cnt == conv_cyc - 16'h0001);

  // [R14] completion dropped on coinciding config write
  assign commit = done && !cfg_wr;

  // ************************************************************
  // peripheral clock gate
  // ************************************************************
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      converter_clock_gate <= 1'b0;
    end else if (wr && addr == OFS_PERIPH_EN) begin
      converter_clock_gate <= wdata[GATE_BIT];
    end
  end

  // ************************************************************
  // control registers
  // ************************************************************
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      converter_mode_reg  <= MODE_RST;
      converter_mode2_reg <= MODE2_RST;
      channel_select_reg  <= CHAN_RST;
      port_config_reg     <= PCFG_RST;
      ref_control_reg     <= REF_RST;
      opamp_active        <= OPAMP_RST;
    // [R22] gated off holds reset values
    end else if (!converter_clock_gate) begin
      converter_mode_reg  <= MODE_RST;
      converter_mode2_reg <= MODE2_RST;
      channel_select_reg  <= CHAN_RST;
      port_config_reg     <= PCFG_RST;
      ref_control_reg     <= REF_RST;
      opamp_active        <= OPAMP_RST;
    end else if (wr_ok) begin
      unique case (addr)
        OFS_MODE: begin
          converter_mode_reg <= wdata[7:0];
        end
        OFS_MODE2: begin
          converter_mode2_reg <= wdata[7:0];
        end
        // [R1] upper channel bits not stored
        OFS_CHAN: begin
          channel_select_reg <= wdata[CHAN_W-1:0];
        end
        OFS_PORTCFG: begin
          port_config_reg <= wdata;
        end
        OFS_REFCTL: begin
          ref_control_reg <= wdata[7:0];
        end
        OFS_OPAMP: begin
          opamp_active <= wdata[OPAMP_N-1:0];
        end
        default: begin
        end
      endcase
    end
  end

  // ************************************************************
  // conversion sequencer
  // ************************************************************
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state <= ST_IDLE;
      cnt   <= '0;
    end else if (!converter_mode_reg.start) begin
      state <= ST_IDLE;
      cnt   <= '0;
    end else begin
      unique case (state)
        ST_IDLE: begin
          state <= ST_SETUP;
          cnt   <= '0;
        end
        // [R7] setup precedes the timed phase
        ST_SETUP: begin
          if (cnt == CNT_W'(SETUP_CYC - 1)) begin
            state <= ST_CONV;
            cnt   <= '0;
          end else begin
            cnt <= cnt + 16'h0001;
          end
        end
        ST_CONV: begin
          if (done) begin
            state <= ST_SETUP;
            cnt   <= '0;
          end else begin
            cnt <= cnt + 16'h0001;
          end
        end
      endcase
    end
  end

  // ************************************************************
  // result and completion
  // ************************************************************
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      result_full_reg <= '0;
    end else if (!converter_clock_gate) begin
      result_full_reg <= '0;
    // [R13] read data sampled from old value this edge
    end else if (commit) begin
      result_full_reg <= sar_code;
    end
  end

  // [R15] channel writes never touch the flag
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      conv_done_flag <= 1'b0;
    // [R23] set wins over a coinciding clear
    end else if (commit) begin
      conv_done_flag <= 1'b1;
    end else if (wr && addr == OFS_FLAG && !wdata[FLAG_DONE_BIT]) begin
      conv_done_flag <= 1'b0;
    end
  end

  // [R23] one-clock completion request
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      conv_done_irq <= 1'b0;
    end else begin
      conv_done_irq <= commit;
    end
  end

  // ************************************************************
  // pin synchroniser and port view
  // ************************************************************
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pin_meta <= '0;
      pin_sync <= '0;
    end else begin
      pin_meta <= port_pins;
      pin_sync <= pin_meta;
    end
  end

  // [R4] analog pins read as zero
  genvar gi;
  generate
    for (gi = 0; gi < PIN_W; gi++) begin : g_pin
      assign port_view[gi] = pin_sync[gi] & ~port_config_reg[gi];
    end
  endgenerate

  // ************************************************************
  // analog side controls
  // ************************************************************
  // [R19] op-amp n owns channels 3n..3n+2; only 3n+2 (output) stays usable
  always_comb begin
    chan_blocked = 1'b0;
    for (int n = 0; n < OPAMP_N; n++) begin
      if (opamp_active[n] && (channel_select_reg == CHAN_W'(3 * n) ||
                              channel_select_reg == CHAN_W'(3 * n + 1))) begin
        chan_blocked = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      comparator_on <= 1'b0;
      sample_on     <= 1'b0;
      mux           <= '0;
      ref_on        <= 1'b0;
      ref_gain      <= 1'b0;
    end else begin
      comparator_on <= converter_mode_reg.cmp_en;
      sample_on     <= (state == ST_CONV);
      mux.sel       <= channel_select_reg;
      mux.en        <= converter_mode_reg.start && !chan_blocked;
      ref_on        <= ref_control_reg[REF_ON_BIT];
      ref_gain      <= ref_control_reg[REF_GAIN_BIT];
    end
  end

  // ************************************************************
  // read port
  // ************************************************************
  // [R22] gated off reads return reset values, except the done flag and the port input view
  // [R21] full and upper result views
  // [R18] result reads reflect last committed value only
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdata <= '0;
    end else if (rd) begin
      unique case (addr)
        OFS_MODE:      rdata <= {8'h00, converter_mode_reg};
        OFS_MODE2:     rdata <= {8'h00, converter_mode2_reg};
        OFS_CHAN:      rdata <= {12'h000, channel_select_reg};
        OFS_PORTCFG:   rdata <= port_config_reg;
        OFS_REFCTL:    rdata <= {8'h00, ref_control_reg};
        OFS_RES_FULL:  rdata <= {4'h0, result_full_reg};
        OFS_RES_UPPER: rdata <= {8'h00, result_full_reg[RES_W-1 -: UPPER_W]};
        OFS_FLAG:      rdata <= {15'h0000, conv_done_flag};
        OFS_PORT_IN:   rdata <= port_view;
        OFS_PERIPH_EN: rdata <= {15'h0000, converter_clock_gate};
        OFS_OPAMP:     rdata <= {13'h0000, opamp_active};
        default:       rdata <= 16'h0000;
      endcase
    end else begin
      rdata <= 16'h0000;
    end
  end

endmodule
`default_nettype wire

// >>> adcsc_asserts.sv
`timescale 1ns/1ps
`default_nettype none
// ****************
// port checks
// ****************
module adcsc_asserts
  import adcsc_pkg::*;
(
  input wire logic        clk,
  input wire logic        rstn,
  input wire logic [3:0]  addr,
  input wire logic [15:0] wdata,
  input wire logic        wr,
  input wire logic        rd,
  input wire logic [15:0] rdata,
  input wire logic        comparator_on,
  input wire logic        sample_on,
  input wire adcsc_mux_t  mux,
  input wire logic        ref_on,
  input wire logic        conv_done_irq
);
  logic        gate;
  logic [1:0]  off_cnt;
  logic [15:0] pcfg;
  logic [4:0]  low_cnt;
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // shadow of gate and port config; cleared while gated
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      gate    <= 1'b0;
      off_cnt <= 2'h0;
      pcfg    <= 16'h0000;
    end else begin
      if (wr && addr == OFS_PERIPH_EN) gate <= wdata[GATE_BIT];
      off_cnt <= gate ? 2'h0 : (off_cnt == 2'h3 ? 2'h3 : off_cnt + 2'h1);
      if (!gate) pcfg <= 16'h0000;
      else if (wr && addr == OFS_PORTCFG) pcfg <= wdata;
    end
  end
  // cycles since conversion phase, saturating
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) low_cnt <= 5'h1f;
    else low_cnt <= sample_on ? 5'h00 : (low_cnt == 5'h1f ? 5'h1f : low_cnt + 5'h01);
  end
  sequence s_irq_quiet;
    !conv_done_irq [*8];
  endsequence
  a_irq_quiet_gap: assert property (conv_done_irq |=> s_irq_quiet)
    else $error("completion pulse not isolated");
  a_irq_after_conv: assert property (conv_done_irq |-> low_cnt <= 5'h03)
    else $error("completion pulse without conversion phase");
  a_setup_before_conv: assert property ($rose(sample_on) |-> low_cnt >= 5'd24)
    else $error("conversion phase without setup");
  a_upper_narrow: assert property (rd && addr == OFS_RES_UPPER |=> rdata[15:8] == 8'h00)
    else $error("upper result wider than 8 bits");
  a_full_narrow: assert property (rd && addr == OFS_RES_FULL |=> rdata[15:12] == 4'h0)
    else $error("full result wider than 12 bits");
  a_port_analog_zero: assert property (rd && addr == OFS_PORT_IN |=> (rdata & pcfg) == 16'h0000)
    else $error("analog pin reads nonzero");
  a_gate_off_idle: assert property (off_cnt == 2'h3 |-> !(comparator_on | sample_on | mux.en | ref_on))
    else $error("outputs active while gated");
  a_gate_read_reset: assert property (off_cnt == 2'h3 && rd && (addr == OFS_MODE || addr == OFS_CHAN) |=>
    rdata == 16'h0000)
    else $error("gated control register reads nonzero");
endmodule
bind adcsc_top adcsc_asserts i_adcsc_asserts (.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr),
  .rd(rd), .rdata(rdata), .comparator_on(comparator_on), .sample_on(sample_on), .mux(mux), .ref_on(ref_on),
  .conv_done_irq(conv_done_irq));
`default_nettype wire

// >>> adcsc_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module adcsc_top_tb
  import adcsc_pkg::*;
;
  logic        clk = 0, rstn = 0, wr = 0, rd = 0;
  logic [3:0]  addr = 0;
  logic [15:0] wdata = 0, port_pins = 0, rdata, v;
  logic [11:0] sar_code = 0, exp_res;
  logic        comparator_on, sample_on, ref_on, ref_gain, conv_done_irq;
  adcsc_mux_t  mux;
  logic [31:0] seed = 32'h843f9f1d;
  int          err_count = 0, checked = 0, samp_tot = 0, t_irq, s_irq, t0, s0;
  always #4 clk = ~clk;
  always @(posedge clk) if (sample_on === 1'b1) samp_tot <= samp_tot + 1;
  adcsc_top i_adcsc_top (.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .sar_code(sar_code), .port_pins(port_pins), .comparator_on(comparator_on), .sample_on(sample_on),
    .mux(mux), .ref_on(ref_on), .ref_gain(ref_gain), .conv_done_irq(conv_done_irq));
  // ****************
  // helpers
  // ****************
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] r;
    r = s ^ (s << 13);
    r = r ^ (r >> 17);
    return r ^ (r << 5);
  endfunction
  task complete_run;
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task chk(input string n, input logic [15:0] e, input logic [15:0] g);
    checked++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task rd_reg(input logic [3:0] a);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask
  // bounded wait; a lost pulse ends the run
  task wait_irq;
    int i;
    i = 0;
    do begin
      @(negedge clk);
      i++;
    end while (conv_done_irq !== 1'b1 && i < 3000);
    if (i >= 3000) begin
      err_count++;
      $display("[FAIL] irq expected 1 seen 0");
      complete_run;
    end
    t_irq = int'($time / 8);
    s_irq = samp_tot;
  endtask
  // ****************
  // sequence
  // ****************
  initial begin
    int ts, ch, p;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    wr_reg(OFS_MODE, 16'h0081);
    rd_reg(OFS_MODE); chk("mode gated", 16'h0000, v);
    chk("cmp gated", 16'h0000, 16'(comparator_on));
    $display("gate test done");
    wr_reg(OFS_PERIPH_EN, 16'h0001);
    seed = xs(seed);
    port_pins <= seed[15:0];
    wr_reg(OFS_PORTCFG, 16'h00f0);
    rd_reg(OFS_PORT_IN); chk("port in", seed[15:0] & 16'hff0f, v);
    // upper channel bits zero; channel 5 is an analog pin
    wr_reg(OFS_CHAN, 16'h0005);
    $display("port test done");
    // pin direction lives outside this block; internal reference unused
    for (ts = 0; ts < 3; ts++) begin
      wr_reg(OFS_MODE, 16'h0001);
      // comparator settles 1 us before start; so no result discarded
      repeat (CLK_MHZ) @(posedge clk);
      wr_reg(OFS_FLAG, 16'h0000);
      seed = xs(seed);
      sar_code <= seed[11:0];
      exp_res = seed[11:0];
      // normal mode only, no boost wait needed
      wr_reg(OFS_MODE, {8'h00, 2'b10, 3'(ts), 3'b001});
      wait_irq;
      t0 = t_irq;
      s0 = s_irq;
      seed = xs(seed);
      sar_code <= seed[11:0];
      rd_reg(OFS_RES_FULL); chk("result", 16'(exp_res), v);
      rd_reg(OFS_RES_UPPER); chk("upper", 16'(exp_res[11:4]), v);
      rd_reg(OFS_FLAG); chk("flag", 16'h0001, v);
      exp_res = seed[11:0];
      wait_irq;
      p = SETUP_CYC + (CONV_BASE_CYC << ts);
      chk("period", 16'(p), 16'(t_irq - t0));
      chk("conv len", 16'(CONV_BASE_CYC << ts), 16'(s_irq - s0));
      $display("timing test %0d done", ts);
    end
    // channel write spans both possible completion cycles
    t0 = t_irq;
    seed = xs(seed);
    sar_code <= seed[11:0];
    repeat (p - 2) @(posedge clk);
    wr <= 1'b1;
    addr <= OFS_CHAN;
    wdata <= 16'h0005;
    repeat (2) @(posedge clk);
    wr <= 1'b0;
    seed = xs(seed);
    sar_code <= seed[11:0];
    rd_reg(OFS_RES_FULL); chk("kept result", 16'(exp_res), v);
    rd_reg(OFS_FLAG); chk("flag kept", 16'h0001, v);
    wait_irq;
    chk("skip period", 16'(2 * p), 16'(t_irq - t0));
    rd_reg(OFS_RES_FULL); chk("next result", 16'(seed[11:0]), v);
    $display("conflict test done");
    // op-amp set up while stopped, then conversion restarted
    wr_reg(OFS_MODE, 16'h0001);
    // channels 0 to 7 analog before they are selected
    wr_reg(OFS_PORTCFG, 16'h00ff);
    wr_reg(OFS_OPAMP, 16'h0001);
    wr_reg(OFS_FLAG, 16'h0000);
    wr_reg(OFS_MODE, 16'h0081);
    for (ch = 0; ch < 4; ch++) begin
      wr_reg(OFS_CHAN, 16'(ch));
      repeat (2) @(posedge clk);
      #1 chk("mux en", 16'(ch >= 2), 16'(mux.en));
      chk("mux sel", 16'(ch), 16'(mux.sel));
    end
    $display("opamp test done");
    // start cleared before the block is gated off
    wr_reg(OFS_MODE, 16'h0000);
    wr_reg(OFS_PERIPH_EN, 16'h0000);
    rd_reg(OFS_MODE); chk("mode off", 16'h0000, v);
    chk("sample off", 16'h0000, 16'(sample_on));
    $display("gate off test done");
    complete_run;
  end
endmodule
`default_nettype wire
